// ==== core/scp_defs.svh ====
/*
  Constants of the serial control port: byte layout, bit positions, fifo size.
  Assumes it is included by bare name from every file that needs the constants.
*/
// Operation
// - SPI read: release attention only at bit-6 rising edge when nothing pending.
// - released attention stays high until next rising edge, then re-asserts if pending.
// - I2C read: release attention only at last-bit rising edge when nothing pending.
// - attention line is open drain: device only pulls it low.
// - SPI data output goes high impedance once select is raised.
// - SPI data input is sampled on the rising serial clock edge.
// - I2C data line changes only after a falling serial clock edge.
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_BYTE_W 8
`define SCP_FIFO_DEPTH 32
`define SCP_DEV_ADDR 7'h2a
`define SCP_FIRST_BIT 3'h0
`define SCP_LAST_BIT 3'h7
`define SCP_SPI_REL_BIT 3'h6
`define SCP_I2C_REL_BIT 3'h7
`define SCP_IDLE_FILL 8'hff
`endif

// ==== core/scp_pkg.sv ====
/*
  Types of the serial control port: transfer states, sampled pins, block state.
  Assumes the constants header is available to the including files.
*/
package scp_pkg;

	// transfer phase of the control port
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK} scp_state_t;

	// one sample of every pin that comes from the host
	typedef struct packed {
		logic scl;
		logic sda;
		logic sel_b;
		logic sdin;
		logic mode;
	} scp_pins_t;

	// all flip-flops of the port controller
	typedef struct packed {
		scp_pins_t s1;
		scp_pins_t s2;
		scp_pins_t prev;
		scp_state_t st;
		logic [2:0] cnt;
		logic rw;
		logic [7:0] sh;
		logic ack_done;
		logic hold;
		logic attn_low;
		logic od_low;
		logic sdo;
		logic sdo_oe;
		logic sda_oe;
		logic [7:0] rx_data;
		logic rx_valid;
		logic pop_due; // spi byte in the shifter still owed to the fifo
	} scp_regs_t;

endpackage : scp_pkg

// ==== core/scp_fifo.sv ====
/*
  Byte fifo between the decoder core and the serial read path.
  Assumes DEPTH is a power of two; one clock, active-low asynchronous reset.
*/
`timescale 1ns/1ns
`include "scp_defs.svh"

module scp_fifo #(
	parameter int WIDTH = `SCP_BYTE_W,
	parameter int DEPTH = `SCP_FIFO_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic in_rdy;
		logic [WIDTH-1:0] q;
		logic q_vld;
	} scp_fifo_st_t;

	scp_fifo_st_t r_ff;
	scp_fifo_st_t nxt_r;
	logic push;
	logic pop;

	// handshakes on both sides
	assign push = in_valid_in & r_ff.in_rdy;
	assign pop = out_ready_in & r_ff.q_vld;

	// pointer and count update; head word registered from the next state
	always_comb begin
		nxt_r = r_ff;
		if (push) begin
			nxt_r.mem[r_ff.wp] = in_data_in;
			nxt_r.wp = AW'(r_ff.wp + 1'b1);
		end
		if (pop) begin
			nxt_r.rp = AW'(r_ff.rp + 1'b1);
		end
		nxt_r.cnt = (AW+1)'(r_ff.cnt + (AW+1)'(push) - (AW+1)'(pop));
		nxt_r.in_rdy = nxt_r.cnt != (AW+1)'(DEPTH);
		nxt_r.q_vld = nxt_r.cnt != '0;
		nxt_r.q = nxt_r.mem[nxt_r.rp];
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign in_ready_out = r_ff.in_rdy;
	assign out_data_out = r_ff.q;
	assign out_valid_out = r_ff.q_vld;

endmodule : scp_fifo

// ==== core/scp_ctrl_port.sv ====
/*
  Serial control port slave: SPI or I2C framing, read data from a byte fifo,
  written bytes out as one-cycle strobes, open-drain attention request line.
  Assumes all host pins are asynchronous to MCLK_IN and far slower than it.
*/
`timescale 1ns/1ns
`include "scp_defs.svh"

module scp_ctrl_port (
	input wire logic MCLK_IN,
	input wire logic RST_B_IN,
	input wire logic MODE_I2C_IN,
	input wire logic CTRL_SERIAL_CLOCK_IN,
	input wire logic CTRL_SELECT_B_IN,
	input wire logic CTRL_SERIAL_IN_IN,
	output logic CTRL_SERIAL_OUT_OUT,
	output logic CTRL_SERIAL_OUT_OE_OUT,
	input wire logic CTRL_SERIAL_BIDIR_IN,
	output logic CTRL_SERIAL_BIDIR_OUT,
	output logic CTRL_SERIAL_BIDIR_OE_OUT,
	output logic HOST_ATTENTION_REQ_OUT,
	output logic HOST_ATTENTION_REQ_OE_OUT,
	input wire logic [7:0] TX_DATA_IN,
	input wire logic TX_VALID_IN,
	output logic TX_READY_OUT,
	output logic [7:0] RX_DATA_OUT,
	output logic RX_VALID_OUT
);

	scp_pkg::scp_regs_t r_ff;
	scp_pkg::scp_regs_t nxt_r;
	scp_pkg::scp_pins_t pin_now;
	logic i2c;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic sel_fall;
	logic din;
	logic reading;
	logic [2:0] rel_bit;
	logic do_load;
	logic pop;
	logic pend;
	logic [7:0] fifo_q;
	logic [7:0] load_byte;
	logic out_bit;
	logic drive;

	////////////////////////////////////////////////////////////////////////////
	// read data buffer

	scp_fifo #(
		.WIDTH(`SCP_BYTE_W),
		.DEPTH(`SCP_FIFO_DEPTH)
	) u_fifo (
		.clk_in(MCLK_IN),
		.rst_b_in(RST_B_IN),
		.in_data_in(TX_DATA_IN),
		.in_valid_in(TX_VALID_IN),
		.in_ready_out(TX_READY_OUT),
		.out_data_out(fifo_q),
		.out_valid_out(pend),
		.out_ready_in(pop)
	);

	////////////////////////////////////////////////////////////////////////////
	// pin sampling and edge events, all from the second sync stage

	assign pin_now = '{scl: CTRL_SERIAL_CLOCK_IN, sda: CTRL_SERIAL_BIDIR_IN,
		sel_b: CTRL_SELECT_B_IN, sdin: CTRL_SERIAL_IN_IN, mode: MODE_I2C_IN};
	assign i2c = r_ff.s2.mode;
	assign rise = r_ff.s2.scl & ~r_ff.prev.scl;
	assign fall = ~r_ff.s2.scl & r_ff.prev.scl;
	assign start = i2c & r_ff.s2.scl & r_ff.prev.scl & r_ff.prev.sda & ~r_ff.s2.sda;
	assign stop = i2c & r_ff.s2.scl & r_ff.prev.scl & ~r_ff.prev.sda & r_ff.s2.sda;
	assign sel_fall = ~i2c & r_ff.prev.sel_b & ~r_ff.s2.sel_b;
	assign din = i2c ? r_ff.s2.sda : r_ff.s2.sdin;
	assign reading = r_ff.st == scp_pkg::ST_READ;
	assign rel_bit = i2c ? `SCP_I2C_REL_BIT : `SCP_SPI_REL_BIT;

	// next read byte taken at a falling edge; empty fifo sends fill bytes
	assign do_load = fall & ((reading & r_ff.cnt == `SCP_FIRST_BIT) |
		(r_ff.st == scp_pkg::ST_ACK & r_ff.ack_done & r_ff.rw & i2c));
	// keep byte for restart: spi pops only at the byte's first rise
	assign pop = i2c ? (do_load & pend) :
		(rise & reading & r_ff.cnt == `SCP_FIRST_BIT & r_ff.pop_due);
	assign load_byte = pend ? fifo_q : `SCP_IDLE_FILL;

	////////////////////////////////////////////////////////////////////////////
	// transfer sequencer

	always_comb begin
		nxt_r = r_ff;
		out_bit = 1'b0;
		drive = 1'b0;
		nxt_r.s1 = pin_now;
		nxt_r.s2 = r_ff.s1;
		nxt_r.prev = r_ff.s2;
		nxt_r.rx_valid = 1'b0;
		nxt_r.od_low = 1'b0;
		case (r_ff.st)
			scp_pkg::ST_IDLE: begin
				nxt_r.cnt = `SCP_FIRST_BIT;
			end
			scp_pkg::ST_ADDR: begin
				if (rise) begin
					nxt_r.sh = {r_ff.sh[6:0], din};
					nxt_r.cnt = r_ff.cnt + 3'h1;
					if (r_ff.cnt == `SCP_LAST_BIT) begin
						nxt_r.rw = din;
						if (r_ff.sh[6:0] != `SCP_DEV_ADDR) begin
							nxt_r.st = scp_pkg::ST_IDLE;
						end else if (i2c) begin
							nxt_r.st = scp_pkg::ST_ACK;
						end else begin
							nxt_r.st = din ? scp_pkg::ST_READ : scp_pkg::ST_WRITE;
						end
					end
				end
			end
			scp_pkg::ST_ACK: begin
				// acknowledge driven and dropped on falling edges
				if (fall & ~r_ff.ack_done) begin
					nxt_r.sda_oe = 1'b1;
				end else if (fall) begin
					nxt_r.sda_oe = 1'b0;
					nxt_r.ack_done = 1'b0;
					nxt_r.st = r_ff.rw ? scp_pkg::ST_READ : scp_pkg::ST_WRITE;
				end
				if (rise) begin
					nxt_r.ack_done = 1'b1;
				end
			end
			scp_pkg::ST_WRITE: begin
				if (rise) begin
					nxt_r.sh = {r_ff.sh[6:0], din};
					nxt_r.cnt = r_ff.cnt + 3'h1;
					if (r_ff.cnt == `SCP_LAST_BIT) begin
						nxt_r.rx_data = {r_ff.sh[6:0], din};
						nxt_r.rx_valid = 1'b1;
						if (i2c) begin
							nxt_r.st = scp_pkg::ST_ACK;
						end
					end
				end
			end
			scp_pkg::ST_READ: begin
				if (rise) begin
					nxt_r.cnt = r_ff.cnt + 3'h1;
					if (i2c & r_ff.cnt == `SCP_LAST_BIT) begin
						nxt_r.st = scp_pkg::ST_RACK;
					end
				end
				if (fall & r_ff.cnt != `SCP_FIRST_BIT) begin
					nxt_r.sh = {r_ff.sh[6:0], 1'b0};
					out_bit = r_ff.sh[6];
					drive = 1'b1;
				end
			end
			scp_pkg::ST_RACK: begin
				// host acknowledge: low asks for another byte
				if (fall) begin
					nxt_r.sda_oe = 1'b0;
				end
				if (rise) begin
					nxt_r.st = din ? scp_pkg::ST_IDLE : scp_pkg::ST_READ;
				end
			end
			default: begin
				nxt_r.st = scp_pkg::ST_IDLE;
			end
		endcase
		if (do_load) begin
			nxt_r.sh = load_byte;
			nxt_r.pop_due = ~i2c & pend;
			out_bit = load_byte[7];
			drive = 1'b1;
		end
		// owed byte settled by its pop, or left in the fifo when select rises
		if (pop | r_ff.s2.sel_b) begin
			nxt_r.pop_due = 1'b0;
		end
		// read bits change only on falling edges
		if (drive & i2c) begin
			nxt_r.sda_oe = ~out_bit;
		end else if (drive) begin
			nxt_r.sdo = out_bit;
		end
		// frame start and end
		if (i2c) begin
			if (start | stop) begin
				nxt_r.st = start ? scp_pkg::ST_ADDR : scp_pkg::ST_IDLE;
				nxt_r.cnt = `SCP_FIRST_BIT;
				nxt_r.sda_oe = 1'b0;
				nxt_r.ack_done = 1'b0;
			end
		end else begin
			nxt_r.sda_oe = 1'b0;
			if (r_ff.s2.sel_b) begin
				nxt_r.st = scp_pkg::ST_IDLE;
			end else if (sel_fall) begin
				nxt_r.st = scp_pkg::ST_ADDR;
				nxt_r.cnt = `SCP_FIRST_BIT;
			end
		end
		// output only while selected and reading
		nxt_r.sdo_oe = ~i2c & ~r_ff.s2.sel_b & nxt_r.st == scp_pkg::ST_READ;
		// attention request
		if (r_ff.hold) begin
			// stay released until next rising edge or until the read ends
			if (rise | ~(reading | r_ff.st == scp_pkg::ST_RACK)) begin
				nxt_r.hold = 1'b0;
				nxt_r.attn_low = pend;
			end
		end else if (reading) begin
			if (rise & r_ff.cnt == rel_bit & ~pend) begin
				nxt_r.attn_low = 1'b0;
				nxt_r.hold = 1'b1;
			end else if (pend) begin
				nxt_r.attn_low = 1'b1;
			end
		end else begin
			nxt_r.attn_low = pend;
		end
	end

	// state register
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// outputs straight from the state register
	assign CTRL_SERIAL_OUT_OUT = r_ff.sdo;
	assign CTRL_SERIAL_OUT_OE_OUT = r_ff.sdo_oe;
	assign CTRL_SERIAL_BIDIR_OUT = r_ff.od_low;
	assign CTRL_SERIAL_BIDIR_OE_OUT = r_ff.sda_oe;
	assign HOST_ATTENTION_REQ_OUT = r_ff.od_low;
	assign HOST_ATTENTION_REQ_OE_OUT = r_ff.attn_low;
	assign RX_DATA_OUT = r_ff.rx_data;
	assign RX_VALID_OUT = r_ff.rx_valid;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RST_B_IN);

	sequence spi_release_s;
		!i2c && reading && rise && r_ff.cnt == `SCP_SPI_REL_BIT && !pend && !r_ff.hold;
	endsequence

	sequence i2c_release_s;
		i2c && reading && rise && r_ff.cnt == `SCP_I2C_REL_BIT && !pend && !r_ff.hold;
	endsequence

	sequence held_rise_s;
		r_ff.hold && rise && reading;
	endsequence

	spi_release_pt_a: assert property (
		$fell(HOST_ATTENTION_REQ_OE_OUT) && $past(reading) && !$past(i2c)
			|-> $past(rise) && $past(r_ff.cnt) == `SCP_SPI_REL_BIT)
		else $error("spi attention released at wrong bit");

	spi_release_do_a: assert property (
		spi_release_s |=> !HOST_ATTENTION_REQ_OE_OUT ##0 r_ff.hold)
		else $error("spi attention not released");

	held_high_a: assert property (
		r_ff.hold |-> !HOST_ATTENTION_REQ_OE_OUT)
		else $error("attention low while held released");

	reassert_a: assert property (
		held_rise_s ##0 pend |=> HOST_ATTENTION_REQ_OE_OUT && !r_ff.hold)
		else $error("attention not reasserted with data pending");

	i2c_release_a: assert property (
		i2c_release_s |=> !HOST_ATTENTION_REQ_OE_OUT ##1 r_ff.st == scp_pkg::ST_RACK)
		else $error("i2c attention not released at last bit");

	i2c_release_pt_a: assert property (
		$fell(HOST_ATTENTION_REQ_OE_OUT) && $past(reading) && $past(i2c)
			|-> $past(rise) && $past(r_ff.cnt) == `SCP_I2C_REL_BIT)
		else $error("i2c attention released at wrong bit");

	open_drain_a: assert property (
		$rose(HOST_ATTENTION_REQ_OE_OUT) |-> $past(pend) && !HOST_ATTENTION_REQ_OUT)
		else $error("attention driven without pending data");

	spi_hiz_a: assert property (
		!i2c && r_ff.s2.sel_b |=> !CTRL_SERIAL_OUT_OE_OUT)
		else $error("spi output driven while deselected");

	spi_sample_a: assert property (
		!i2c && rise && r_ff.st == scp_pkg::ST_WRITE && !r_ff.s2.sel_b
			|=> r_ff.sh[0] == $past(r_ff.s2.sdin))
		else $error("spi input bit not sampled on rising edge");

	i2c_change_a: assert property (
		$changed(CTRL_SERIAL_BIDIR_OE_OUT) && $past(i2c)
			|-> $past(fall) || $past(start) || $past(stop))
		else $error("i2c data changed outside falling edge");

	idle_attn_a: assert property (
		!reading && !r_ff.hold && r_ff.st != scp_pkg::ST_RACK
			|=> HOST_ATTENTION_REQ_OE_OUT == $past(pend))
		else $error("attention does not follow pending data");

endmodule : scp_ctrl_port

// ==== testbench/scp_host_model.sv ====
/*
  host model: bus master of the control port, spi and i2c framing.
  assumes the bench resolves the released and open-drain lines into wire levels.
*/
`timescale 1ns/1ns
`include "scp_defs.svh"
module scp_host_model (
	output logic sclk_out,
	output logic sel_b_out,
	output logic sdin_out,
	output logic sda_low_out,
	input wire logic sdo_in,
	input wire logic sda_in
);
	// idle levels: select high, clock still, data line released
	initial begin
		sclk_out = 1'b0;
		sel_b_out = 1'b1;
		sdin_out = 1'b0;
		sda_low_out = 1'b0;
	end
	////////////////////////////////////////
	// one bit: data set while clock low, read back at the rise
	task automatic bit_x(input logic i2c, input logic d, output logic q);
		#10;
		if (i2c) sda_low_out = ~d;
		else sdin_out = d;
		#52 sclk_out = 1'b1;
		q = i2c ? sda_in : sdo_in;
		#63 sclk_out = 1'b0;
	endtask : bit_x
	// eight bits, msb first
	task automatic byte_x(input logic i2c, input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) bit_x(i2c, d[i], q[i]);
	endtask : byte_x
	task automatic spi_open(input logic [6:0] addr, input logic rw);
		logic [7:0] q;
		sel_b_out = 1'b0;
		#200 byte_x(1'b0, {addr, rw}, q);
	endtask : spi_open
	// end of frame: select high after the last fall
	task automatic spi_close();
		#40 sel_b_out = 1'b1;
		#200;
	endtask : spi_close
	task automatic i2c_open(input logic rw, output logic ack);
		logic [7:0] q;
		sda_low_out = 1'b1;
		#300 sclk_out = 1'b0;
		#100 byte_x(1'b1, {`SCP_DEV_ADDR, rw}, q);
		bit_x(1'b1, 1'b1, ack);
	endtask : i2c_open
	// stop: data rises while clock high, clock then stands high
	task automatic i2c_stop();
		#20 sda_low_out = 1'b1;
		#62 sclk_out = 1'b1;
		#62 sda_low_out = 1'b0;
		#300;
	endtask : i2c_stop
endmodule : scp_host_model

// ==== testbench/tb_top.sv ====
/*
  bench of the control port: reset, spi write and read, fifo fill, i2c frames.
  assumes the port controller, its fifo and the host model are compiled first.
*/
`timescale 1ns/1ns
`include "scp_defs.svh"
module tb_top;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic mode_i2c = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic sdo_last = 1'b0;
	logic sclk, sel_b, sdin, sda_low, sdo_o, sdo_oe, sda_o, sda_oe;
	logic attn_o, attn_oe, tx_ready, rx_valid;
	logic [7:0] rx_data, rx_last;
	int n_fail = 0;
	int num_checks = 0;
	int n_glitch = 0;
	// wire levels: released output toggles, open-drain lines pulled up
	wire sdo_w = sdo_oe ? sdo_o : ~sdo_last;
	wire sda_w = ~((sda_oe & ~sda_o) | sda_low);
	wire attn_w = attn_oe ? attn_o : 1'b1;
	always #5 mclk = ~mclk;
	// last driven data bit and last written byte
	always @(posedge mclk) begin
		if (sdo_oe) sdo_last <= sdo_o;
		if (rx_valid) rx_last <= rx_data;
	end
	// data drive must not move while clock high
	always @(sda_oe) if (mode_i2c && sclk) n_glitch++;
	scp_ctrl_port i_scp_ctrl_port (
		.MCLK_IN(mclk),
		.RST_B_IN(rst_b),
		.MODE_I2C_IN(mode_i2c),
		.CTRL_SERIAL_CLOCK_IN(sclk),
		.CTRL_SELECT_B_IN(sel_b),
		.CTRL_SERIAL_IN_IN(sdin),
		.CTRL_SERIAL_OUT_OUT(sdo_o),
		.CTRL_SERIAL_OUT_OE_OUT(sdo_oe),
		.CTRL_SERIAL_BIDIR_IN(sda_w),
		.CTRL_SERIAL_BIDIR_OUT(sda_o),
		.CTRL_SERIAL_BIDIR_OE_OUT(sda_oe),
		.HOST_ATTENTION_REQ_OUT(attn_o),
		.HOST_ATTENTION_REQ_OE_OUT(attn_oe),
		.TX_DATA_IN(tx_data),
		.TX_VALID_IN(tx_valid),
		.TX_READY_OUT(tx_ready),
		.RX_DATA_OUT(rx_data),
		.RX_VALID_OUT(rx_valid)
	);
	scp_host_model i_scp_host_model (
		.sclk_out(sclk),
		.sel_b_out(sel_b),
		.sdin_out(sdin),
		.sda_low_out(sda_low),
		.sdo_in(sdo_w),
		.sda_in(sda_w)
	);
	////////////////////////////////////////
	// compare helpers and byte offer
	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte
	task automatic push(input logic [7:0] d);
		@(negedge mclk);
		tx_data = d;
		tx_valid = 1'b1;
		@(negedge mclk);
		tx_valid = 1'b0;
	endtask : push
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	// reset values, then fifo open for bytes
	task automatic test_reset();
		repeat (5) @(negedge mclk);
		chk_bit("tx ready in reset", 1'b0, tx_ready);
		chk_bit("attn in reset", 1'b1, attn_w);
		chk_bit("sdo oe in reset", 1'b0, sdo_oe);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		chk_bit("tx ready after reset", 1'b1, tx_ready);
		$display("test reset done");
	endtask : test_reset
	// spi write, then a frame to another address is ignored
	task automatic test_spi_write();
		logic [7:0] q;
		i_scp_host_model.spi_open(`SCP_DEV_ADDR, 1'b0);
		i_scp_host_model.byte_x(1'b0, 8'h5c, q);
		i_scp_host_model.spi_close();
		chk_byte("spi written byte", 8'h5c, rx_last);
		i_scp_host_model.spi_open(7'h15, 1'b0);
		i_scp_host_model.byte_x(1'b0, 8'h33, q);
		i_scp_host_model.spi_close();
		chk_byte("foreign frame", 8'h5c, rx_last);
		$display("test spi write done");
	endtask : test_spi_write
	// fill the fifo, drain it, release and rearm at the last byte
	task automatic test_spi_read();
		logic [7:0] q;
		for (int i = 0; i < 33; i++) push(8'h40 + 8'(i));
		chk_bit("tx ready full", 1'b0, tx_ready);
		chk_bit("attn pending", 1'b0, attn_w);
		i_scp_host_model.spi_open(`SCP_DEV_ADDR, 1'b1);
		for (int i = 0; i < 31; i++) begin
			i_scp_host_model.byte_x(1'b0, 8'hff, q);
			chk_byte("spi read", 8'h40 + 8'(i), q);
		end
		for (int k = 1; k <= 8; k++) begin
			i_scp_host_model.bit_x(1'b0, 1'b1, q[8-k]);
			if (k == 6) chk_bit("attn before rule bit", 1'b0, attn_w);
			if (k == 7) chk_bit("attn at rule bit", 1'b1, attn_w);
			if (k == 7) push(8'ha7);
		end
		repeat (2) @(negedge mclk);
		chk_bit("attn rearmed", 1'b0, attn_w);
		chk_byte("spi last byte", 8'h5f, q);
		i_scp_host_model.spi_close();
		chk_bit("sdo released", 1'b0, sdo_oe);
		i_scp_host_model.spi_open(`SCP_DEV_ADDR, 1'b1);
		i_scp_host_model.byte_x(1'b0, 8'hff, q);
		chk_byte("spi reread", 8'ha7, q);
		i_scp_host_model.byte_x(1'b0, 8'hff, q);
		chk_byte("spi empty fill", `SCP_IDLE_FILL, q);
		i_scp_host_model.spi_close();
		chk_bit("attn idle", 1'b1, attn_w);
		$display("test spi read done");
	endtask : test_spi_read
	// i2c write with acks, then read with release at the last bit
	task automatic test_i2c();
		logic [7:0] q;
		logic a;
		i_scp_host_model.i2c_stop();
		@(negedge mclk);
		mode_i2c = 1'b1;
		repeat (5) @(negedge mclk);
		i_scp_host_model.i2c_open(1'b0, a);
		chk_bit("i2c address ack", 1'b0, a);
		i_scp_host_model.byte_x(1'b1, 8'h96, q);
		i_scp_host_model.bit_x(1'b1, 1'b1, a);
		chk_bit("i2c data ack", 1'b0, a);
		i_scp_host_model.i2c_stop();
		chk_byte("i2c written byte", 8'h96, rx_last);
		push(8'hc3);
		repeat (4) @(negedge mclk);
		chk_bit("i2c attn pending", 1'b0, attn_w);
		i_scp_host_model.i2c_open(1'b1, a);
		for (int k = 1; k <= 8; k++) begin
			i_scp_host_model.bit_x(1'b1, 1'b1, q[8-k]);
			if (k == 7) chk_bit("i2c attn before last", 1'b0, attn_w);
		end
		chk_bit("i2c attn at last bit", 1'b1, attn_w);
		i_scp_host_model.bit_x(1'b1, 1'b1, a);
		i_scp_host_model.i2c_stop();
		chk_byte("i2c read byte", 8'hc3, q);
		chk_bit("i2c drive steady", 1'b1, n_glitch == 0);
		$display("test i2c done");
	endtask : test_i2c
	////////////////////////////////////////
	// main sequence
	initial begin
		test_reset();
		test_spi_write();
		test_spi_read();
		test_i2c();
		give_verdict();
	end
	// watchdog against a hung handshake
	initial begin
		#300000;
		n_fail++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule : tb_top
